// file: rtl/itb_top.sv
// Interpolated trajectory input buffer with status word and event
`timescale 1ns/100ps
`include "itb_params.svh"

module itb_top (
    input wire logic CLOCK_IN,                       // Drive clock, 40 MHz
    input wire logic RST_B_IN,                       // Async reset, active low
    input wire itb_pkg::itb_od_req_type OD_REQ_IN,   // Dictionary access request
    input wire logic ERR_CLEAR_IN,                   // Clears the three error flags
    input wire logic GEN_TAKE_IN,                    // Generator asks for a segment
    output logic OD_ACK_OUT,                         // Access answered
    output logic OD_ERR_OUT,                         // Access refused
    output logic [31:0] OD_RDATA_OUT,                // Read data
    output logic GEN_SEG_VALID_OUT,                  // Segment handed out
    output itb_pkg::itb_seg_type GEN_SEG_OUT,        // Segment contents
    output logic signed [1:0] GEN_TIME_ADJ_OUT,      // Servo cycle trim
    output logic STATUS_EVENT_OUT                    // Status transmit event
);
    import itb_pkg::*;

    // ****************************************
    // State
    // ****************************************
    itb_seg_type mem [0:`ITB_DEPTH-1];
    logic [`ITB_PTR_W-1:0] wr_ptr_reg;
    logic [`ITB_PTR_W-1:0] rd_ptr_reg;
    logic [`ITB_CNT_W-1:0] count_reg;
    logic [15:0] next_id_reg;
    itb_submode_type submode_reg;
    logic [31:0] pos_reg;
    logic [7:0] time_reg;
    logic [31:0] vel_reg;
    logic [7:0] const_time_reg;
    logic seq_err_reg;
    logic overflow_reg;
    logic underflow_reg;

    logic wr;
    logic rd;
    logic is_rec;
    logic hit;
    logic wr_ok;
    logic sub_ok;
    itb_submode_type sub_next;
    logic commit;
    logic tag_ok;
    logic push;
    logic pop;
    logic seq_set;
    logic ovf_set;
    logic unf_set;
    logic [7:0] free_cnt;
    logic [31:0] status_word;
    itb_seg_type new_seg;

    assign wr = OD_REQ_IN.valid & OD_REQ_IN.write;
    assign rd = OD_REQ_IN.valid & ~OD_REQ_IN.write;
    assign is_rec = OD_REQ_IN.index == `ITB_IDX_RECORD;

    // ****************************************
    // Status word
    // ****************************************
    // free locations
    assign free_cnt = 8'(`ITB_DEPTH) - {2'h0, count_reg};
    always_comb begin
        status_word = 32'h0;
        status_word[`ITB_ST_NEXT_LSB +: 16] = next_id_reg;
        status_word[`ITB_ST_FREE_LSB +: 8] = free_cnt;
        status_word[`ITB_ST_SEQ_ERR] = seq_err_reg;
        status_word[`ITB_ST_OVERFLOW] = overflow_reg;
        status_word[`ITB_ST_UNDERFLOW] = underflow_reg;
        status_word[`ITB_ST_EMPTY] = count_reg == '0;
    end

    // ****************************************
    // Access decode
    // ****************************************
    // only the four documented codes are taken
    always_comb begin
        sub_ok = 1'b1;
        sub_next = ITB_LIN_CONST;
        case (OD_REQ_IN.wdata[15:0])
            `ITB_SUBMODE_CONST: sub_next = ITB_LIN_CONST;
            `ITB_SUBMODE_SYNC: sub_next = ITB_LIN_SYNC;
            `ITB_SUBMODE_VAR: sub_next = ITB_LIN_VAR;
            `ITB_SUBMODE_PVT: sub_next = ITB_PVT;
            default: sub_ok = 1'b0;
        endcase
    end
    always_comb begin
        hit = 1'b0;
        wr_ok = 1'b0;
        case (OD_REQ_IN.index)
            `ITB_IDX_STATUS, `ITB_IDX_NEXT_SEG: hit = OD_REQ_IN.subindex == 8'h00;
            `ITB_IDX_SUBMODE: begin
                hit = OD_REQ_IN.subindex == 8'h00;
                wr_ok = hit & sub_ok;
            end
            `ITB_IDX_RECORD: begin
                hit = OD_REQ_IN.subindex == `ITB_SUB_POSITION
                    || OD_REQ_IN.subindex == `ITB_SUB_TIME
                    || OD_REQ_IN.subindex == `ITB_SUB_VELOCITY;
                wr_ok = hit;
            end
            `ITB_IDX_TIME_PERIOD: begin
                hit = OD_REQ_IN.subindex == `ITB_SUB_TIME_VALUE;
                wr_ok = hit;
            end
            default: hit = 1'b0;
        endcase
    end

    // ****************************************
    // Record commit
    // ****************************************
    always_comb begin
        commit = 1'b0;
        if (wr && is_rec) begin
            case (submode_reg)
                // position write commits in constant time modes
                ITB_LIN_CONST, ITB_LIN_SYNC: commit = OD_REQ_IN.subindex == `ITB_SUB_POSITION;
                // time write commits position and time
                ITB_LIN_VAR: commit = OD_REQ_IN.subindex == `ITB_SUB_TIME;
                // velocity write latches the whole record
                ITB_PVT: commit = OD_REQ_IN.subindex == `ITB_SUB_VELOCITY;
                default: commit = 1'b0;
            endcase
        end
    end

    always_comb begin
        new_seg.position = (OD_REQ_IN.subindex == `ITB_SUB_POSITION) ? OD_REQ_IN.wdata : pos_reg;
        // master time ignored in constant time modes
        if (submode_reg == ITB_LIN_CONST || submode_reg == ITB_LIN_SYNC) begin
            new_seg.time_ms = const_time_reg;
        end else if (OD_REQ_IN.subindex == `ITB_SUB_TIME) begin
            new_seg.time_ms = OD_REQ_IN.wdata[7:0];
        end else begin
            new_seg.time_ms = time_reg;
        end
        if (submode_reg == ITB_PVT) begin
            new_seg.velocity = (OD_REQ_IN.subindex == `ITB_SUB_VELOCITY)
                ? OD_REQ_IN.wdata : vel_reg;
        end else begin
            new_seg.velocity = 32'h0;
        end
        new_seg.end_of_move = new_seg.time_ms == 8'h00;
    end

    // tag matches low id bits, error blocks
    assign tag_ok = OD_REQ_IN.tag == next_id_reg[2:0];
    assign seq_set = commit & ~seq_err_reg & ~tag_ok;
    // full buffer drops the segment and flags it
    assign ovf_set = commit & ~seq_err_reg & tag_ok & (count_reg == `ITB_CNT_W'(`ITB_DEPTH));
    assign push = commit & ~seq_err_reg & tag_ok & ~ovf_set;
    assign pop = GEN_TAKE_IN & (count_reg != '0);
    assign unf_set = GEN_TAKE_IN & (count_reg == '0);

    // ****************************************
    // Configuration and staging registers
    // ****************************************
    always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            submode_reg <= ITB_LIN_CONST;
            pos_reg <= 32'h0;
            time_reg <= 8'h00;
            vel_reg <= 32'h0;
            const_time_reg <= `ITB_CONST_TIME_RST;
        end else if (wr && wr_ok) begin
            if (OD_REQ_IN.index == `ITB_IDX_SUBMODE) begin
                submode_reg <= sub_next;
            end
            if (OD_REQ_IN.index == `ITB_IDX_TIME_PERIOD) begin
                const_time_reg <= OD_REQ_IN.wdata[7:0];
            end
            if (is_rec) begin
                case (OD_REQ_IN.subindex)
                    `ITB_SUB_POSITION: pos_reg <= OD_REQ_IN.wdata;
                    `ITB_SUB_TIME: time_reg <= OD_REQ_IN.wdata[7:0];
                    `ITB_SUB_VELOCITY: vel_reg <= OD_REQ_IN.wdata;
                    default: ;
                endcase
            end
        end
    end

    // ****************************************
    // Buffer storage and pointers
    // ****************************************
    // Storage has no reset so it can map onto RAM
    always_ff @(posedge CLOCK_IN) begin
        if (push) begin
            mem[wr_ptr_reg] <= new_seg;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            next_id_reg <= 16'h0000;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
                // advance expected id per accepted segment
                next_id_reg <= next_id_reg + 16'h0001;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    // ****************************************
    // Error flags, set wins over clear
    // ****************************************
    always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            seq_err_reg <= 1'b0;
            overflow_reg <= 1'b0;
            underflow_reg <= 1'b0;
        end else begin
            seq_err_reg <= seq_set | (seq_err_reg & ~ERR_CLEAR_IN);
            overflow_reg <= ovf_set | (overflow_reg & ~ERR_CLEAR_IN);
            underflow_reg <= unf_set | (underflow_reg & ~ERR_CLEAR_IN);
        end
    end

    // ****************************************
    // Generator side
    // ****************************************
    always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            GEN_SEG_VALID_OUT <= 1'b0;
            GEN_SEG_OUT <= '0;
            GEN_TIME_ADJ_OUT <= 2'sb00;
        end else begin
            GEN_SEG_VALID_OUT <= pop;
            if (pop) begin
                GEN_SEG_OUT <= mem[rd_ptr_reg];
                // in ITB_LIN_CONST only, nearly empty stretches, nearly full shortens
                GEN_TIME_ADJ_OUT <= 2'sb00;
                if (submode_reg == ITB_LIN_CONST && count_reg <= `ITB_LOW_MARK) begin
                    GEN_TIME_ADJ_OUT <= 2'sb01;
                end
                if (submode_reg == ITB_LIN_CONST && count_reg >= `ITB_HIGH_MARK) begin
                    GEN_TIME_ADJ_OUT <= 2'sb11;
                end
            end
        end
    end

    // event on a newly set error or a removal
    always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            STATUS_EVENT_OUT <= 1'b0;
        end else begin
            STATUS_EVENT_OUT <= pop | seq_set | (ovf_set & ~overflow_reg)
                | (unf_set & ~underflow_reg);
        end
    end

    // ****************************************
    // Dictionary answers
    // ****************************************
    always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            OD_ACK_OUT <= 1'b0;
            OD_ERR_OUT <= 1'b0;
            OD_RDATA_OUT <= 32'h0;
        end else begin
            OD_ACK_OUT <= OD_REQ_IN.valid;
            OD_ERR_OUT <= OD_REQ_IN.valid & ~(rd ? hit : wr_ok);
            OD_RDATA_OUT <= 32'h0;
            if (rd && hit) begin
                case (OD_REQ_IN.index)
                    `ITB_IDX_STATUS: OD_RDATA_OUT <= status_word;
                    // same id as the status low half
                    `ITB_IDX_NEXT_SEG: OD_RDATA_OUT <= {16'h0, next_id_reg};
                    `ITB_IDX_SUBMODE: OD_RDATA_OUT <= {16'h0, 14'(submode_reg == ITB_LIN_CONST ? 0 : '1),
                        2'(~submode_reg + 2'b01)};
                    `ITB_IDX_RECORD: begin
                        OD_RDATA_OUT <= vel_reg;
                        if (OD_REQ_IN.subindex == `ITB_SUB_POSITION) begin
                            OD_RDATA_OUT <= pos_reg;
                        end
                        if (OD_REQ_IN.subindex == `ITB_SUB_TIME) begin
                            OD_RDATA_OUT <= {24'h0, time_reg};
                        end
                    end
                    `ITB_IDX_TIME_PERIOD: OD_RDATA_OUT <= {24'h0, const_time_reg};
                    default: OD_RDATA_OUT <= 32'h0;
                endcase
            end
        end
    end
endmodule

// file: rtl/itb_params.svh
// Offsets, field positions, reset values and counts of the trajectory buffer
`ifndef ITB_PARAMS_SVH
`define ITB_PARAMS_SVH

// ****************************************
// Object dictionary indices and subindices
// ****************************************
`define ITB_IDX_STATUS 16'h2012
`define ITB_IDX_NEXT_SEG 16'h2013
`define ITB_IDX_SUBMODE 16'h60c0
`define ITB_IDX_RECORD 16'h60c1
`define ITB_IDX_TIME_PERIOD 16'h60c2
`define ITB_SUB_POSITION 8'h01
`define ITB_SUB_TIME 8'h02
`define ITB_SUB_VELOCITY 8'h03
`define ITB_SUB_TIME_VALUE 8'h01

// ****************************************
// Submode selector codes
// ****************************************
`define ITB_SUBMODE_CONST 16'h0000
`define ITB_SUBMODE_SYNC 16'hffff
`define ITB_SUBMODE_VAR 16'hfffe
`define ITB_SUBMODE_PVT 16'hfffd

// ****************************************
// Status word fields
// ****************************************
`define ITB_ST_NEXT_LSB 0
`define ITB_ST_FREE_LSB 16
`define ITB_ST_SEQ_ERR 24
`define ITB_ST_OVERFLOW 25
`define ITB_ST_UNDERFLOW 26
`define ITB_ST_EMPTY 31

// ****************************************
// Buffer size, watermarks and reset values
// ****************************************
`define ITB_DEPTH 32
`define ITB_PTR_W 5
`define ITB_CNT_W 6
`define ITB_LOW_MARK 6'h04
`define ITB_HIGH_MARK 6'h1c
`define ITB_CONST_TIME_RST 8'h0a

`endif

// file: rtl/itb_pkg.sv
// Types shared by the trajectory buffer and its users
package itb_pkg;

    typedef enum logic [1:0] {
        ITB_LIN_CONST = 2'b00,
        ITB_LIN_SYNC = 2'b01,
        ITB_LIN_VAR = 2'b10,
        ITB_PVT = 2'b11
    } itb_submode_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] index;
        logic [7:0] subindex;
        logic [2:0] tag;
        logic [31:0] wdata;
    } itb_od_req_type;

    typedef struct packed {
        logic signed [31:0] position;
        logic [7:0] time_ms;
        logic signed [31:0] velocity;
        logic end_of_move;
    } itb_seg_type;

endpackage

// file: testbench/itb_assertions.sv
// Port checker for the trajectory buffer
`timescale 1ns/100ps
`include "itb_params.svh"
module itb_checker (
    input wire logic CLOCK_IN,                       // Clock
    input wire logic RST_B_IN,                       // Reset
    input wire itb_pkg::itb_od_req_type OD_REQ_IN,   // Request
    input wire logic ERR_CLEAR_IN,                   // Clear
    input wire logic GEN_TAKE_IN,                    // Take
    input wire logic OD_ACK_OUT,                     // Ack
    input wire logic OD_ERR_OUT,                     // Refused
    input wire logic [31:0] OD_RDATA_OUT,            // Read data
    input wire logic GEN_SEG_VALID_OUT,              // Handout
    input wire itb_pkg::itb_seg_type GEN_SEG_OUT,    // Segment
    input wire logic signed [1:0] GEN_TIME_ADJ_OUT,  // Trim
    input wire logic STATUS_EVENT_OUT                // Event
);
    import itb_pkg::*;
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RST_B_IN);
    // Answer to an accepted read of the status word
    property stat_ans(p);
        OD_ACK_OUT && !OD_ERR_OUT && $past(OD_REQ_IN.valid && !OD_REQ_IN.write
            && OD_REQ_IN.index == `ITB_IDX_STATUS) |-> p;
    endproperty
    // ********************
    // Assertions
    // ********************
    ack_after_req_a: assert property (OD_REQ_IN.valid |=> OD_ACK_OUT)
        else $error("request not answered");
    ack_has_cause_a: assert property (OD_ACK_OUT |-> $past(OD_REQ_IN.valid))
        else $error("answer without request");
    rdata_quiet_a: assert property (!OD_ACK_OUT |-> OD_RDATA_OUT == 32'h0)
        else $error("read data outside answer");
    reserved_zero_a: assert property (stat_ans(OD_RDATA_OUT[30:27] == 4'h0))
        else $error("reserved status bits set");
    empty_free_a: assert property (stat_ans(OD_RDATA_OUT[31] == (OD_RDATA_OUT[23:16] == 8'h20)))
        else $error("empty flag disagrees with free count");
    ro_refused_a: assert property (OD_REQ_IN.valid && OD_REQ_IN.write
        && OD_REQ_IN.index[15:1] == 15'h1009 |=> OD_ACK_OUT && OD_ERR_OUT)
        else $error("status write not refused");
    pop_event_a: assert property (GEN_SEG_VALID_OUT |-> STATUS_EVENT_OUT)
        else $error("no event on handout");
    event_cause_a: assert property (STATUS_EVENT_OUT |->
        $past(GEN_TAKE_IN || OD_REQ_IN.valid) || $past(GEN_TAKE_IN || OD_REQ_IN.valid, 2))
        else $error("event without cause");
    pop_cause_a: assert property (GEN_SEG_VALID_OUT |-> $past(GEN_TAKE_IN))
        else $error("handout without take");
    end_move_a: assert property (GEN_SEG_VALID_OUT |->
        GEN_SEG_OUT.end_of_move == (GEN_SEG_OUT.time_ms == 8'h00))
        else $error("end of move flag wrong");
    adj_range_a: assert property (GEN_SEG_VALID_OUT |-> GEN_TIME_ADJ_OUT != 2'sb10)
        else $error("trim beyond one cycle");
    pop_c: cover property (GEN_SEG_VALID_OUT);
    refuse_c: cover property (OD_ACK_OUT && OD_ERR_OUT);
    event_c: cover property (STATUS_EVENT_OUT && !GEN_SEG_VALID_OUT);
endmodule
bind itb_top itb_checker u_chk (.CLOCK_IN(CLOCK_IN), .RST_B_IN(RST_B_IN),
    .OD_REQ_IN(OD_REQ_IN), .ERR_CLEAR_IN(ERR_CLEAR_IN), .GEN_TAKE_IN(GEN_TAKE_IN),
    .OD_ACK_OUT(OD_ACK_OUT), .OD_ERR_OUT(OD_ERR_OUT), .OD_RDATA_OUT(OD_RDATA_OUT),
    .GEN_SEG_VALID_OUT(GEN_SEG_VALID_OUT), .GEN_SEG_OUT(GEN_SEG_OUT),
    .GEN_TIME_ADJ_OUT(GEN_TIME_ADJ_OUT), .STATUS_EVENT_OUT(STATUS_EVENT_OUT));

// file: testbench/itb_master_model.sv
// Network master model writing trajectory records
`timescale 1ns/100ps
module itb_master_model (
    input wire logic clk_in,                  // Drive clock
    output itb_pkg::itb_od_req_type req_out,  // Request
    input wire logic ack_in,                  // Answer
    input wire logic err_in,                  // Refused
    input wire logic [31:0] rdata_in          // Read data
);
    import itb_pkg::*;
    initial req_out = '0;
    task automatic access(input logic w, input logic [15:0] idx, input logic [7:0] sub,
        input logic [2:0] tg, input logic [31:0] d, output logic e, output logic [31:0] rd);
        @(posedge clk_in);
        #1;
        req_out = {1'b1, w, idx, sub, tg, d};
        @(posedge clk_in);
        #1;
        // Released fields flip so stale values are never trusted
        req_out = {1'b0, ~{w, idx, sub, tg, d}};
        e = (ack_in === 1'b1) ? err_in : 1'bx;
        rd = rdata_in;
    endtask
    // fields in order, tag on each
    task automatic push(input logic [15:0] sm, input logic [2:0] tg, input logic [31:0] pos,
        input logic [7:0] t, input logic [31:0] vel, output logic e);
        logic [31:0] rd;
        access(1'b1, 16'h60c1, 8'h01, tg, pos, e, rd);
        if (sm == 16'hfffe || sm == 16'hfffd) access(1'b1, 16'h60c1, 8'h02, tg, {24'h0, t}, e, rd);
        if (sm == 16'hfffd) access(1'b1, 16'h60c1, 8'h03, tg, vel, e, rd);
    endtask
endmodule

// file: testbench/itb_top_tb.sv
// Self-checking bench of the trajectory buffer
`timescale 1ns/100ps
`include "itb_params.svh"
`define CHK(a, x) begin tests_run++; if ((a) !== (x)) begin n_mismatch++; \
    $display("[ERR] %0t got %h exp %h", $time, a, x); end end
module itb_top_tb;
    import itb_pkg::*;
    logic clk, rst_b, clr, take, ack, err, sv, ev, v, ev_s, e;
    logic [31:0] rdata, s;
    itb_od_req_type req;
    itb_seg_type seg;
    logic signed [1:0] adj;
    int n_mismatch = 0;
    int tests_run = 0;
    int ev_cnt = 0;
    logic [15:0] nid = 16'h0;
    itb_top DUT (.CLOCK_IN(clk), .RST_B_IN(rst_b), .OD_REQ_IN(req), .ERR_CLEAR_IN(clr),
        .GEN_TAKE_IN(take), .OD_ACK_OUT(ack), .OD_ERR_OUT(err), .OD_RDATA_OUT(rdata),
        .GEN_SEG_VALID_OUT(sv), .GEN_SEG_OUT(seg), .GEN_TIME_ADJ_OUT(adj),
        .STATUS_EVENT_OUT(ev));
    itb_master_model mst (.clk_in(clk), .req_out(req), .ack_in(ack), .err_in(err),
        .rdata_in(rdata));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) if (ev === 1'b1) ev_cnt++;
    // ********************
    // Helpers
    // ********************
    function automatic logic [31:0] st(logic [15:0] id, logic [7:0] fr, logic [2:0] f);
        return {fr == 8'h20, 4'h0, f, fr, id};
    endfunction
    task automatic rd(input logic [15:0] idx, output logic [31:0] v);
        mst.access(1'b0, idx, 8'h00, 3'h0, 32'h0, e, v);
        `CHK(e, 1'b0)
    endtask
    task automatic mode(input logic [15:0] c);
        mst.access(1'b1, `ITB_IDX_SUBMODE, 8'h00, 3'h0, {{16{c[15]}}, c}, e, s);
    endtask
    task automatic pop(output logic vo, output logic eo);
        @(posedge clk);
        #1;
        take = 1'b1;
        @(posedge clk);
        #1;
        take = 1'b0;
        vo = sv;
        eo = ev;
    endtask
    task automatic clear;
        @(posedge clk);
        #1;
        clr = 1'b1;
        @(posedge clk);
        #1;
        clr = 1'b0;
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ********************
    // Scenarios
    // ********************
    task automatic t_reset;
        rd(`ITB_IDX_STATUS, s);
        `CHK(s, st(16'h0, 8'h20, 3'h0))
        rd(`ITB_IDX_NEXT_SEG, s);
        `CHK(s, 32'h0)
    endtask
    task automatic t_mode;
        logic [15:0] c [4] = '{16'h0000, 16'hffff, 16'hfffe, 16'hfffd};
        foreach (c[i]) begin
            mode(c[i]);
            rd(`ITB_IDX_SUBMODE, s);
            `CHK(s[15:0], c[i])
        end
        mode(16'h0005);
        `CHK(e, 1'b1)
        mst.access(1'b1, `ITB_IDX_NEXT_SEG, 8'h00, 3'h0, 32'h1, e, s);
        `CHK(e, 1'b1)
        mst.access(1'b0, 16'h1234, 8'h00, 3'h0, 32'h0, e, s);
        `CHK(e, 1'b1)
    endtask
    task automatic t_const;
        mode(16'h0000);
        mst.access(1'b1, `ITB_IDX_TIME_PERIOD, `ITB_SUB_TIME_VALUE, 3'h0, 32'h14, e, s);
        mst.access(1'b1, `ITB_IDX_RECORD, `ITB_SUB_TIME, 3'h0, 32'h3, e, s);
        mst.push(16'h0000, nid[2:0], 32'h8000_0001, 8'h00, 32'h0, e);
        nid++;
        rd(`ITB_IDX_STATUS, s);
        `CHK(s, st(nid, 8'h1f, 3'h0))
        pop(v, ev_s);
        `CHK({v, ev_s}, 2'b11)
        `CHK(seg, {32'h8000_0001, 8'h14, 32'h0, 1'b0})
        `CHK(adj, 2'sb01)
    endtask
    task automatic t_var;
        mode(16'hfffe);
        mst.access(1'b1, `ITB_IDX_RECORD, `ITB_SUB_POSITION, nid[2:0], 32'hffff_fff0, e, s);
        rd(`ITB_IDX_STATUS, s);
        `CHK(s[23:16], 8'h20)
        mst.access(1'b1, `ITB_IDX_RECORD, `ITB_SUB_TIME, nid[2:0], 32'h5, e, s);
        nid++;
        rd(`ITB_IDX_STATUS, s);
        `CHK(s[23:16], 8'h1f)
        pop(v, ev_s);
        `CHK({v, seg.position, seg.time_ms, adj}, {1'b1, 32'hffff_fff0, 8'h05, 2'b00})
    endtask
    task automatic t_pvt;
        mode(16'hfffd);
        mst.access(1'b1, `ITB_IDX_RECORD, `ITB_SUB_POSITION, nid[2:0], 32'h42, e, s);
        mst.access(1'b1, `ITB_IDX_RECORD, `ITB_SUB_TIME, nid[2:0], 32'h0, e, s);
        rd(`ITB_IDX_STATUS, s);
        `CHK(s[23:16], 8'h20)
        mst.access(1'b1, `ITB_IDX_RECORD, `ITB_SUB_VELOCITY, nid[2:0], 32'hffff_fffb, e, s);
        nid++;
        pop(v, ev_s);
        `CHK({v, seg}, {1'b1, 32'h42, 8'h00, 32'hffff_fffb, 1'b1})
    endtask
    task automatic t_seq;
        int c0;
        mode(16'h0000);
        c0 = ev_cnt;
        mst.push(16'h0000, nid[2:0] + 3'h1, 32'h77, 8'h00, 32'h0, e);
        rd(`ITB_IDX_STATUS, s);
        `CHK(s, st(nid, 8'h20, 3'h1))
        `CHK(ev_cnt - c0, 1)
        mst.push(16'h0000, nid[2:0], 32'h77, 8'h00, 32'h0, e);
        rd(`ITB_IDX_STATUS, s);
        `CHK(s[23:16], 8'h20)
        clear();
        mst.push(16'h0000, nid[2:0], 32'h77, 8'h00, 32'h0, e);
        nid++;
        pop(v, ev_s);
        `CHK({v, seg.position}, {1'b1, 32'h77})
    endtask
    task automatic t_flow;
        int c0;
        // Let the event of the last handout be counted first
        @(posedge clk);
        #1;
        c0 = ev_cnt;
        pop(v, ev_s);
        `CHK(v, 1'b0)
        rd(`ITB_IDX_STATUS, s);
        `CHK(s, st(nid, 8'h20, 3'h4))
        `CHK(ev_cnt - c0, 1)
        clear();
        c0 = ev_cnt;
        for (int i = 0; i < 33; i++) begin
            mst.push(16'h0000, nid[2:0], 32'h100 + i, 8'h00, 32'h0, e);
            nid++;
        end
        rd(`ITB_IDX_STATUS, s);
        `CHK({s[31], s[25], s[23:16]}, {1'b0, 1'b1, 8'h00})
        `CHK(ev_cnt - c0, 1)
        for (int i = 0; i < 32; i++) begin
            pop(v, ev_s);
            `CHK({v, seg.position}, {1'b1, 32'h100 + i})
            if (i == 0) `CHK(adj, 2'sb11)
        end
    endtask
    initial begin
        rst_b = 1'b0;
        clr = 1'b0;
        take = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        rst_b = 1'b1;
        t_reset();
        t_mode();
        t_const();
        t_var();
        t_pvt();
        t_seq();
        t_flow();
        stop_test();
    end
    // The whole run needs well under two thousand cycles
    initial begin
        #500000;
        n_mismatch++;
        stop_test();
    end
endmodule
